// >>> rtl/hbi_pkg.sv
// package: shared constants and carriers of the host bus port
`default_nettype none
package hbi_pkg;
    localparam int ADDR_W = 15;
    localparam int BASE_W = 12;
    localparam int DATA_W = 32;
    localparam int LANE_W = 4;
    localparam logic [3:0] LANES_ALL = 4'hF;
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [3:0] LANES_LOW16 = 4'h3;
    localparam logic [3:0] LANES_HIGH16 = 4'hC;
    localparam logic [3:0] BE_RST_N = 4'hF;
    localparam logic [14:0] ADDR_RST = 15'h0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [11:0] BASE_RST = 12'h000;
    localparam logic STYLE_SINGLE = 1'h0;
    localparam logic STYLE_BURST = 1'h1;

    // one host transfer as handed to the core side
    typedef struct packed {
        logic [14:0] addr;
        logic [3:0] lanes;
        logic write;
        logic data_port;
        logic [31:0] wdata;
    } hbi_req_s;
endpackage : hbi_pkg
`default_nettype wire

// >>> rtl/hbi_sync2.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module hbi_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // first stage is read only by the second stage
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : hbi_sync2
`default_nettype wire

// >>> rtl/hbi_lane_dec.sv
// byte-lane decode of the active-low lane selects
`timescale 1ns/1ps
`default_nettype none
module hbi_lane_dec (
    input wire logic [3:0] be_n,
    input wire logic dport_n,
    input wire logic bus32,
    output logic [3:0] lanes,
    output logic legal
);
    logic [3:0] be;

    always_comb begin
        be = 4'h0;
        lanes = hbi_pkg::LANES_NONE;
        legal = 1'b0;
        if (!dport_n && bus32) begin
            lanes = hbi_pkg::LANES_ALL;
            legal = 1'b1;
        end else begin
            be = bus32 ? ~be_n : {2'b00, ~be_n[1:0]};
            unique case (be)
                hbi_pkg::LANES_ALL: legal = bus32;
                hbi_pkg::LANES_LOW16, hbi_pkg::LANES_HIGH16: legal = 1'b1;
                4'h1, 4'h2, 4'h4, 4'h8: legal = 1'b1;
                default: legal = 1'b0;
            endcase
            lanes = legal ? be : hbi_pkg::LANES_NONE;
        end
    end
endmodule : hbi_lane_dec
`default_nettype wire

// >>> rtl/hbi_port.sv
// synchronous host bus port: decode, strobes, ready handshake, core crossing
`timescale 1ns/1ps
`default_nettype none
module hbi_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_clk,
    input wire logic [14:0] addr_in,
    input wire logic addr_qualifier_n,
    input wire logic lane0_sel_n,
    input wire logic lane1_sel_n,
    input wire logic lane2_sel_n,
    input wire logic lane3_sel_n,
    input wire logic addr_strobe_n,
    input wire logic data_port_select_n,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [31:0] data_oe,
    output logic local_hit_n,
    input wire logic bus_style_sel,
    input wire logic cycle_strobe_n,
    input wire logic write_not_read,
    output logic sync_ready_n,
    input wire logic ready_return_n,
    input wire logic bus32_sel,
    input wire logic [11:0] base_addr,
    output logic core_req_valid,
    output hbi_pkg::hbi_req_s core_req,
    input wire logic core_rsp_valid,
    input wire logic [31:0] core_rdata
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READY} hbi_state_e;

    // link domain state
    logic [14:0] addr_r, addr_nxt;
    logic aen_r, aen_nxt;
    logic [3:0] be_n_r, be_n_nxt;
    logic ads_prev_r, ads_prev_nxt;
    hbi_state_e st_r, st_nxt;
    logic wr_r, wr_nxt;
    logic burst_r, burst_nxt;
    logic [3:0] lanes_r, lanes_nxt;
    hbi_pkg::hbi_req_s req_r, req_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // core domain state
    logic req_seen_r, req_seen_nxt;
    logic pend_r, pend_nxt;
    hbi_pkg::hbi_req_s creq_r, creq_nxt;
    logic [31:0] rsp_data_r, rsp_data_nxt;
    logic ack_tgl_r, ack_tgl_nxt;
    // crossings and decode
    logic [13:0] cfg_l;
    logic bus32_l;
    logic style_l;
    logic [11:0] base_l;
    logic ack_l;
    logic req_s;
    logic [3:0] lanes_dec;
    logic lanes_ok;
    logic hit;
    logic dport;
    logic sel;
    logic burst_wr;
    logic burst_rd;
    logic start;
    logic done;

    // straps and base address are quasi-static, a level sync is enough
    hbi_sync2 #(.W(14)) u_cfg_sync (
        .clk(bus_clk),
        .rst(rst),
        .d({bus32_sel, bus_style_sel, base_addr}),
        .q(cfg_l)
    );
    assign bus32_l = cfg_l[13];
    assign style_l = cfg_l[12];
    assign base_l = cfg_l[11:0];

    // answer toggle back into the link domain
    hbi_sync2 #(.W(1)) u_ack_sync (
        .clk(bus_clk),
        .rst(rst),
        .d(ack_tgl_r),
        .q(ack_l)
    );

    // request toggle into the core domain
    hbi_sync2 #(.W(1)) u_req_sync (
        .clk(clk_sys),
        .rst(rst),
        .d(req_tgl_r),
        .q(req_s)
    );

    hbi_lane_dec u_lane_dec (
        .be_n(be_n_r),
        .dport_n(data_port_select_n),
        .bus32(bus32_l),
        .lanes(lanes_dec),
        .legal(lanes_ok)
    );

    // address latch: pins are held by the host around the strobe rise
    always_comb begin
        addr_nxt = addr_r;
        aen_nxt = aen_r;
        be_n_nxt = be_n_r;
        ads_prev_nxt = addr_strobe_n;
        if (!ads_prev_r && addr_strobe_n) begin
            addr_nxt = addr_in;
            aen_nxt = addr_qualifier_n;
            be_n_nxt = {lane3_sel_n, lane2_sel_n, lane1_sel_n, lane0_sel_n};
        end
    end

    always_ff @(posedge bus_clk or posedge rst) begin
        if (rst) begin
            addr_r <= hbi_pkg::ADDR_RST;
            aen_r <= 1'b1;
            be_n_r <= hbi_pkg::BE_RST_N;
            ads_prev_r <= 1'b1;
        end else begin
            addr_r <= addr_nxt;
            aen_r <= aen_nxt;
            be_n_r <= be_n_nxt;
            ads_prev_r <= ads_prev_nxt;
        end
    end

    // qualifier high means a memory or dma cycle
    // compare address bits 14..3 with the base
    assign hit = !aen_r && (addr_r[14:3] == base_l);
    assign local_hit_n = !hit;

    // data port select targets the data register directly, on the 32-bit bus only
    assign dport = !data_port_select_n && bus32_l;
    assign sel = (hit || dport) && lanes_ok;

    // burst commands are active-low write and read strobes
    assign burst_wr = !cycle_strobe_n;
    assign burst_rd = !write_not_read;

    // style chooses how a cycle opens and closes
    always_comb begin
        if (style_l == hbi_pkg::STYLE_BURST) begin
            start = sel && (burst_wr ^ burst_rd);
            done = ready_return_n;
        end else begin
            start = sel && !cycle_strobe_n;
            done = !ready_return_n;
        end
    end

    // link state machine: one beat per request to the core
    always_comb begin
        st_nxt = st_r;
        wr_nxt = wr_r;
        burst_nxt = burst_r;
        lanes_nxt = lanes_r;
        req_nxt = req_r;
        req_tgl_nxt = req_tgl_r;
        rdata_nxt = rdata_r;
        unique case (st_r)
            ST_IDLE: begin
                if (start) begin
                    // direction sampled with the cycle strobe
                    wr_nxt = style_l ? burst_wr : write_not_read;
                    burst_nxt = style_l;
                    lanes_nxt = lanes_dec;
                    req_nxt.addr = addr_r;
                    req_nxt.lanes = lanes_dec;
                    req_nxt.write = style_l ? burst_wr : write_not_read;
                    req_nxt.data_port = dport;
                    req_nxt.wdata = data_in;
                    req_tgl_nxt = !req_tgl_r;
                    st_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // ready stays high while the core is busy
                if (ack_l == req_tgl_r) begin
                    rdata_nxt = rsp_data_r;
                    st_nxt = ST_READY;
                end
            end
            ST_READY: begin
                // ready held low until the host closes
                // read data held until ready return
                if (done) begin
                    st_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge bus_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            wr_r <= 1'b0;
            burst_r <= hbi_pkg::STYLE_SINGLE;
            lanes_r <= hbi_pkg::LANES_NONE;
            req_r <= '0;
            req_tgl_r <= 1'b0;
            rdata_r <= hbi_pkg::DATA_RST;
        end else begin
            st_r <= st_nxt;
            wr_r <= wr_nxt;
            burst_r <= burst_nxt;
            lanes_r <= lanes_nxt;
            req_r <= req_nxt;
            req_tgl_r <= req_tgl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign sync_ready_n = (st_r != ST_READY);
    assign data_out = rdata_r;
    // drive only selected lanes of a targeted read
    assign data_oe = (st_r == ST_READY && !wr_r)
        ? {{8{lanes_r[3]}}, {8{lanes_r[2]}}, {8{lanes_r[1]}}, {8{lanes_r[0]}}}
        : hbi_pkg::DATA_RST;

    // core side: the request carrier is stable while the toggle is pending
    always_comb begin
        req_seen_nxt = req_seen_r;
        pend_nxt = pend_r;
        creq_nxt = creq_r;
        rsp_data_nxt = rsp_data_r;
        ack_tgl_nxt = ack_tgl_r;
        if (req_s != req_seen_r) begin
            req_seen_nxt = req_s;
            pend_nxt = 1'b1;
            creq_nxt = req_r;
        end else if (pend_r && core_rsp_valid) begin
            pend_nxt = 1'b0;
            ack_tgl_nxt = !ack_tgl_r;
            if (!creq_r.write) begin
                rsp_data_nxt = core_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_seen_r <= 1'b0;
            pend_r <= 1'b0;
            creq_r <= '0;
            rsp_data_r <= hbi_pkg::DATA_RST;
            ack_tgl_r <= 1'b0;
        end else begin
            req_seen_r <= req_seen_nxt;
            pend_r <= pend_nxt;
            creq_r <= creq_nxt;
            rsp_data_r <= rsp_data_nxt;
            ack_tgl_r <= ack_tgl_nxt;
        end
    end

    assign core_req_valid = pend_r;
    assign core_req = creq_r;

    // checks on the link side
    default clocking cb_link @(posedge bus_clk); endclocking
    default disable iff (rst);

    sequence s_open;
        st_r == ST_IDLE && start;
    endsequence

    sequence s_ready;
        st_r == ST_READY;
    endsequence

    a_qual_blocks_hit: assert property (aen_r |-> local_hit_n)
        else $error("hit asserted with qualifier high");
    a_strobe_latch: assert property ($rose(addr_strobe_n) && !ads_prev_r
        |=> addr_r == $past(addr_in) && aen_r == $past(addr_qualifier_n))
        else $error("address not latched at strobe rise");
    a_hit_compare: assert property (!aen_r && addr_r[14:3] == base_l |-> !local_hit_n)
        else $error("hit missing on base match");
    a_dport_full: assert property (s_open and (dport) |=> lanes_r == hbi_pkg::LANES_ALL)
        else $error("data port access not full word");
    a_narrow_lanes: assert property (!bus32_l |-> lanes_dec[3:2] == 2'b00)
        else $error("upper lane used on narrow bus");
    a_single_dir: assert property (s_open and (!style_l) |=> wr_r == $past(write_not_read))
        else $error("direction not sampled at cycle strobe");
    a_burst_dir: assert property (s_open and (style_l) |=> wr_r == $past(burst_wr))
        else $error("burst command decoded wrongly");
    a_wait_ready_hi: assert property (st_r == ST_WAIT |-> sync_ready_n)
        else $error("ready low before data available");
    a_read_hold: assert property (s_ready and (!burst_r && !wr_r && ready_return_n)
        |=> !sync_ready_n && data_oe != hbi_pkg::DATA_RST)
        else $error("read data dropped before ready return");
    a_single_close: assert property (s_ready and (!burst_r && !ready_return_n)
        |=> sync_ready_n ##1 sync_ready_n)
        else $error("ready not released after return");
    a_write_no_drive: assert property (wr_r || st_r != ST_READY |-> data_oe == '0)
        else $error("data bus driven outside a read");
    a_open_wait: assert property (s_open |=> st_r == ST_WAIT && req_tgl_r != $past(req_tgl_r))
        else $error("cycle start did not issue a request");
endmodule : hbi_port
`default_nettype wire

// >>> dv/hbi_host_model.sv
// host-side model driving the synchronous strobes of the host bus port
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model (
    input wire logic bus_clk,
    input wire logic style,
    input wire logic sync_ready_n,
    input wire logic [31:0] data_in,
    input wire logic [31:0] data_oe,
    output logic [14:0] addr,
    output logic qual_n,
    output logic [3:0] be_n,
    output logic strobe_n,
    output logic dsel_n,
    output logic cyc_n,
    output logic wnr,
    output logic rret_n,
    output logic [31:0] hd
);
    logic [31:0] wd_r = 32'h0000_0000;
    logic [31:0] pat = 32'h5A5A_A5A5;
    logic drive = 1'b0;
    // a released data bus shows a changing pattern, never a stale value
    always @(posedge bus_clk) pat <= ~pat;
    assign hd = drive ? wd_r : pat;
    initial {addr, qual_n, be_n, strobe_n, dsel_n, cyc_n, wnr, rret_n} = '1;
    // address phase held across the strobe rise
    task automatic xfer(input logic [14:0] a, input logic [3:0] be, input logic q,
                        input logic ds, input logic w, input logic [31:0] wd, input int hw,
                        output logic [31:0] rd, output logic [31:0] oe, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge bus_clk);
        {addr, qual_n, be_n, dsel_n, strobe_n} <= {a, q, be, ds, 1'b0};
        drive <= w;
        wd_r <= wd;
        @(posedge bus_clk);
        strobe_n <= 1'b1;
        @(posedge bus_clk);
        // single: strobe and direction; burst: one command low
        cyc_n <= style & ~w;
        wnr <= w;
        rret_n <= ~(style && hw > 0);
        for (n = 0; n < 100 && !ok; n++) begin
            @(posedge bus_clk);
            ok = (sync_ready_n === 1'b0);
        end
        rd = data_in;
        oe = data_oe;
        // data taken before ready returns; burst host wait then accept
        if (ok && !style) rret_n <= 1'b0;
        if (ok && style && hw > 0) begin
            repeat (hw) @(posedge bus_clk);
            rret_n <= 1'b1;
            @(posedge bus_clk);
            ok = (sync_ready_n === 1'b0) && (data_in === rd);
        end
        if (ok && !style) @(posedge bus_clk);
        {cyc_n, wnr, rret_n, dsel_n, drive} <= 5'h1E;
        @(posedge bus_clk);
    endtask : xfer
endmodule : hbi_host_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the synchronous host bus port
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [14:0] A_HIT = {12'h3A5, 3'h2};
    localparam logic [14:0] A_MISS = {12'h3A4, 3'h2};
    localparam logic [31:0] WD = 32'h1234_5678;
    localparam logic [31:0] RD = 32'hC3A5_5A3C;
    logic clk_sys = 1'b0;
    logic bus_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_style_sel = 1'b0;
    logic bus32_sel = 1'b1;
    logic core_rsp_valid = 1'b0;
    logic [31:0] core_rdata = 32'h0000_0000;
    logic [31:0] data_in, data_out, data_oe, hd, rd, oe;
    logic [14:0] addr;
    logic [3:0] be_n;
    logic qual_n, strobe_n, dsel_n, cyc_n, wnr, rret_n, local_hit_n, sync_ready_n, ok;
    logic core_req_valid;
    hbi_pkg::hbi_req_s core_req, got;
    logic busy = 1'b0;
    logic [1:0] dly = 2'h0;
    int nreq = 0;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    always #10 clk_sys = ~clk_sys;
    // link clock: its rising edges never meet a core rising edge, so the crossings see real skew
    always #16 bus_clk = ~bus_clk;
    // device drives only its enabled bits; the host model owns the rest
    assign data_in = (data_out & data_oe) | (hd & ~data_oe);

    hbi_port uut (.clk_sys(clk_sys), .rst(rst), .bus_clk(bus_clk), .addr_in(addr),
        .addr_qualifier_n(qual_n), .lane0_sel_n(be_n[0]), .lane1_sel_n(be_n[1]),
        .lane2_sel_n(be_n[2]), .lane3_sel_n(be_n[3]), .addr_strobe_n(strobe_n),
        .data_port_select_n(dsel_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .local_hit_n(local_hit_n), .bus_style_sel(bus_style_sel),
        .cycle_strobe_n(cyc_n), .write_not_read(wnr), .sync_ready_n(sync_ready_n),
        .ready_return_n(rret_n), .bus32_sel(bus32_sel), .base_addr(12'h3A5),
        .core_req_valid(core_req_valid), .core_req(core_req),
        .core_rsp_valid(core_rsp_valid), .core_rdata(core_rdata));

    hbi_host_model hm (.bus_clk(bus_clk), .style(bus_style_sel), .sync_ready_n(sync_ready_n),
        .data_in(data_in), .data_oe(data_oe), .addr(addr), .qual_n(qual_n), .be_n(be_n),
        .strobe_n(strobe_n), .dsel_n(dsel_n), .cyc_n(cyc_n), .wnr(wnr), .rret_n(rret_n),
        .hd(hd));

    // core side answers each request a few cycles late, so the wait is exercised
    always @(posedge clk_sys) begin
        core_rsp_valid <= 1'b0;
        if (core_req_valid === 1'b1 && !core_rsp_valid && !busy) begin
            busy <= 1'b1;
            dly <= 2'h3;
            got <= core_req;
            nreq <= nreq + 1;
        end else if (busy && dly != 2'h0) dly <= dly - 2'h1;
        else if (busy) begin
            core_rsp_valid <= 1'b1;
            core_rdata <= RD;
            busy <= 1'b0;
        end
    end

    // hang guard, well above the length of all scenarios
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    function automatic logic [31:0] mask(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction : mask

    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        n_tests++;
        if (act !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk

    // straps are synchronised, so give them time to settle
    task automatic straps(input logic s, input logic b32);
        @(posedge clk_sys);
        bus_style_sel <= s;
        bus32_sel <= b32;
        repeat (6) @(posedge bus_clk);
    endtask : straps

    task automatic t_lanes();
        logic [3:0] tab[7] = '{4'h0, 4'h3, 4'hC, 4'hE, 4'hD, 4'hB, 4'h7};
        foreach (tab[i]) begin
            hm.xfer(A_HIT, tab[i], 1'b0, 1'b1, 1'b1, WD, 0, rd, oe, ok);
            chk(32'({ok, got.write, got.lanes}), {26'h0, 2'h3, ~tab[i]});
            chk(got.wdata & mask(~tab[i]), WD & mask(~tab[i]));
            chk(32'({got.addr, local_hit_n}), {A_HIT, 1'b0});
            hm.xfer(A_HIT, tab[i], 1'b0, 1'b1, 1'b0, WD, 0, rd, oe, ok);
            chk(32'({ok, got.write}), 32'h2);
            chk(oe, mask(~tab[i]));
            chk(rd & oe, RD & mask(~tab[i]));
        end
    endtask : t_lanes

    task automatic t_refuse();
        logic [14:0] a[3] = '{A_HIT, A_MISS, A_HIT};
        logic [3:0] be[3] = '{4'h0, 4'h0, 4'h5};
        logic [1:0] qh[3] = '{2'h3, 2'h1, 2'h0};
        int n0;
        foreach (be[i]) begin
            n0 = nreq;
            hm.xfer(a[i], be[i], qh[i][1], 1'b1, 1'b0, WD, 0, rd, oe, ok);
            chk(32'({ok, local_hit_n}), 32'(qh[i][0]));
            chk(32'(nreq - n0), 32'h0);
            chk(data_oe, 32'h0);
        end
    endtask : t_refuse

    task automatic t_dport();
        hm.xfer(A_MISS, 4'hE, 1'b1, 1'b0, 1'b1, WD, 0, rd, oe, ok);
        chk(32'({ok, got.lanes, got.data_port, got.write}), 32'h7F);
        chk(got.wdata, WD);
        hm.xfer(A_MISS, 4'hE, 1'b1, 1'b0, 1'b0, WD, 0, rd, oe, ok);
        chk(oe, 32'hFFFF_FFFF);
        chk(rd, RD);
    endtask : t_dport

    task automatic t_narrow();
        straps(1'b0, 1'b0);
        hm.xfer(A_HIT, 4'h2, 1'b0, 1'b1, 1'b1, WD, 0, rd, oe, ok);
        chk(32'({ok, got.lanes}), 32'h11);
        hm.xfer(A_MISS, 4'hF, 1'b1, 1'b0, 1'b1, WD, 0, rd, oe, ok);
        chk(32'(ok), 32'h0);
        straps(1'b0, 1'b1);
    endtask : t_narrow

    task automatic t_burst();
        straps(1'b1, 1'b1);
        hm.xfer(A_HIT, 4'h0, 1'b0, 1'b1, 1'b1, WD, 0, rd, oe, ok);
        chk(32'({ok, got.write, got.lanes}), 32'h3F);
        chk(got.wdata, WD);
        hm.xfer(A_HIT, 4'h0, 1'b0, 1'b1, 1'b0, WD, 3, rd, oe, ok);
        chk(32'({ok, got.write}), 32'h2);
        chk(rd, RD);
        straps(1'b0, 1'b1);
    endtask : t_burst

    task automatic stop_test();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // reset, idle checks, then each scenario in turn
    initial begin
        repeat (3) @(posedge clk_sys);
        chk(32'({sync_ready_n, local_hit_n, core_req_valid}), 32'h6);
        chk(data_oe, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge bus_clk);
        t_lanes();
        t_refuse();
        t_dport();
        t_narrow();
        t_burst();
        stop_test();
    end
endmodule : tb
`default_nettype wire
